// [blt_top.sv]
// Brownout qualification, line peak tracking and duty limiting.
// Assumes comparator outputs arrive asynchronously from the analog side.
`timescale 1ns/10ps
`default_nettype none
module blt_top
    import blt_pkg::*;
#(
    parameter int LW = 4,
    parameter int LONG_CYCLES = LONG_CYC,
    parameter int RATE_CYCLES = RATE_CYC,
    parameter int QUALIFY_CYCLES = QUALIFY_CYC,
    parameter int SHORT_CYCLES = SHORT_CYC,
    parameter int FILTER_CYCLES = FILTER_CYC,
    parameter int PW = 16
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic supply_on_cmp,
    input wire logic supply_reset_cmp,
    input wire logic supply_inhibit_cmp,
    input wire logic brown_in_cmp,
    input wire logic brown_out_cmp,
    input wire logic line_present_cmp,
    input wire logic [(1<<LW)-2:0] level_cmp,
    input wire logic soft_start_done,
    input wire logic line_changes_allowed,
    input wire logic [3:0] mode_req,
    input wire logic pwm_on_req,
    input wire logic [PW-1:0] period_cycles,
    output logic startup_current_low,
    output logic startup_current_high,
    output logic start_sequence,
    output logic brownout,
    output logic line_fault,
    output logic gate_enable,
    output logic main_gate,
    output logic high_line,
    output logic [LW-1:0] current_peak_line_level,
    output logic [LW-1:0] held_peak_line_level,
    output logic [3:0] mode
);
    localparam int NL = (1 << LW) - 1;
    localparam int NI = 6 + NL;
    localparam logic [LW-1:0] TOP = LW'(NL);

    // ************************************************
    // Input synchronisers
    // ************************************************
    logic [NI-1:0] s1;
    logic [NI-1:0] s2;
    wire [NI-1:0] raw_in = {level_cmp, line_present_cmp, brown_out_cmp, brown_in_cmp,
        supply_inhibit_cmp, supply_reset_cmp, supply_on_cmp};
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            s1 <= '0;
            s2 <= '0;
        end
        else
        begin
            s1 <= raw_in;
            s2 <= s1;
        end
    end
    wire vcc_on = s2[0];
    wire vcc_reset = s2[1];
    wire vcc_inhibit = s2[2];

    // ************************************************
    // Comparator filters
    // ************************************************
    logic [NI-4:0] filt;
    genvar g;
    generate
        for (g = 0; g < NI - 3; g = g + 1)
        begin : g_flt
            blt_filter #(.CYCLES(FILTER_CYCLES)) u_flt (
                .mclk(mclk),
                .rst_n(rst_n),
                .raw(s2[g+3]),
                .clean(filt[g])
            );
        end
    endgenerate
    logic charging;
    // Comparators are meaningless while the supply pin is being charged
    wire bi = filt[0] && !charging;
    wire bo = !filt[1] && !charging;
    wire lp = filt[2] || charging;
    wire [NL-1:0] lvl = filt[NI-4:3];

    // ************************************************
    // Startup and brownout sequencer
    // ************************************************
    blt_state_e state;
    blt_state_e next_state;
    logic [31:0] qcnt;
    logic [31:0] scnt;
    logic [31:0] lcnt;
    logic short_run;
    logic long_run;
    wire q_done = qcnt == 32'(QUALIFY_CYCLES);
    wire s_done = short_run && scnt == 32'(SHORT_CYCLES - 1);
    wire l_done = long_run && lcnt == 32'(LONG_CYCLES - 1);
    assign charging = state == BLT_ST_CHARGE || state == BLT_ST_RECHARGE;

    always_comb
    begin
        next_state = state;
        case (state)
            BLT_ST_CHARGE: if (vcc_on) next_state = BLT_ST_QUALIFY;
            BLT_ST_QUALIFY: if (q_done) next_state = BLT_ST_RECHARGE;
                else if (vcc_reset) next_state = BLT_ST_CHARGE;
            BLT_ST_RECHARGE: if (vcc_on) next_state = BLT_ST_RUN;
            BLT_ST_RUN: if (l_done || !lp) next_state = BLT_ST_FAULT;
            BLT_ST_FAULT: if (vcc_reset || (lp && !brownout && q_done))
                next_state = BLT_ST_CHARGE;
            default: next_state = BLT_ST_CHARGE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            state <= BLT_ST_CHARGE;
        else
            state <= next_state;
    end

    // Brown-in qualification counter, saturates at the delay
    always_ff @(posedge mclk)
    begin
        if (!rst_n || !bi)
            qcnt <= '0;
        else if (!q_done)
            qcnt <= qcnt + 1'b1;
    end

    // Short then long stop timers; a brown-out starts the short one only when both are idle
    always_ff @(posedge mclk)
    begin
        if (!rst_n || state != BLT_ST_RUN || q_done)
        begin
            short_run <= 1'b0;
            long_run <= 1'b0;
            scnt <= '0;
            lcnt <= '0;
        end
        else
        begin
            if (bo && !short_run && !long_run)
            begin
                short_run <= 1'b1;
                scnt <= '0;
            end
            else if (s_done)
            begin
                short_run <= 1'b0;
                long_run <= !bi;
            end
            else if (short_run)
                scnt <= scnt + 1'b1;
            if (long_run)
                lcnt <= lcnt + 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            brownout <= 1'b0;
            line_fault <= 1'b0;
        end
        else if (state == BLT_ST_CHARGE)
        begin
            brownout <= 1'b0;
            line_fault <= 1'b0;
        end
        else if (state == BLT_ST_RUN)
        begin
            if (l_done)
                brownout <= 1'b1;
            if (!lp)
                line_fault <= 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            startup_current_low <= 1'b0;
            startup_current_high <= 1'b0;
            start_sequence <= 1'b0;
        end
        else
        begin
            startup_current_low <= next_state inside {BLT_ST_CHARGE, BLT_ST_RECHARGE};
            startup_current_high <= next_state inside {BLT_ST_CHARGE, BLT_ST_RECHARGE}
                && vcc_inhibit;
            start_sequence <= state == BLT_ST_RECHARGE && vcc_on;
        end
    end
    assign gate_enable = state == BLT_ST_RUN && !l_done && lp;

    // ************************************************
    // Line peak tracker
    // ************************************************
    logic [LW-1:0] meas;
    logic [LW-1:0] maxv;
    logic [LW-1:0] cand;
    logic cand_valid;
    logic first_done;
    logic [31:0] rcnt;
    logic [LW-1:0] inst;
    always_comb
    begin
        inst = '0;
        for (int i = 0; i < NL; i++)
            if (lvl[i])
                inst = LW'(i + 1);
    end
    wire [LW:0] max_plus = {1'b0, maxv} + (LW+1)'(PEAK_ADD);
    wire [LW-1:0] peak_sat = max_plus > (LW+1)'(NL) ? TOP : max_plus[LW-1:0];
    wire fell = {1'b0, inst} + (LW+1)'(FALL_STEPS) <= {1'b0, maxv} && maxv != '0;
    wire rate_tick = rcnt == 32'(RATE_CYCLES - 1);
    wire allow = soft_start_done && line_changes_allowed;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            meas <= '0;
            maxv <= '0;
            cand <= '0;
            cand_valid <= 1'b0;
            first_done <= 1'b0;
        end
        else if (!charging)
        begin
            meas <= inst;
            if (inst > maxv)
                maxv <= inst;
            else if (fell)
            begin
                maxv <= inst;
                first_done <= 1'b1;
                cand <= peak_sat;
                cand_valid <= cand == peak_sat;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n || rate_tick)
            rcnt <= '0;
        else
            rcnt <= rcnt + 1'b1;
    end

    // Held peak starts at the low-line level
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            held_peak_line_level <= '0;
        else if (allow && first_done && cand_valid && rate_tick)
        begin
            if (cand > held_peak_line_level && held_peak_line_level != TOP)
                held_peak_line_level <= held_peak_line_level + 1'b1;
            else if (cand < held_peak_line_level && held_peak_line_level != '0)
                held_peak_line_level <= held_peak_line_level - 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            current_peak_line_level <= '0;
            high_line <= 1'b0;
        end
        else if (allow)
        begin
            current_peak_line_level <= meas;
            high_line <= held_peak_line_level[LW-1];
        end
    end

    // ************************************************
    // Mode and duty limiting
    // ************************************************
    wire mode_ok = mode_req inside {BLT_MODE_ACF, BLT_MODE_TRANS, BLT_MODE_DCM, BLT_MODE_SKIP};
    logic [PW-1:0] pcnt;
    // In ACF mode the duty cap is the smaller of the percentage and the fixed off-time bound; other modes use the percentage
    wire [PW+7:0] pct_on = (PW+8)'(period_cycles) * (PW+8)'(DUTY_PCT) / (PW+8)'(PCT_FULL);
    wire [PW-1:0] off_on = period_cycles > PW'(MIN_OFF_CYC) ?
        period_cycles - PW'(MIN_OFF_CYC) : '0;
    wire [PW-1:0] max_on = (mode == BLT_MODE_ACF && off_on < pct_on[PW-1:0]) ?
        off_on : pct_on[PW-1:0];
    wire end_cyc = pcnt >= period_cycles - 1'b1 || period_cycles == '0;
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            mode <= BLT_MODE_DCM;
        else if (mode_ok)
            mode <= mode_req;
    end
    always_ff @(posedge mclk)
    begin
        if (!rst_n || end_cyc)
            pcnt <= '0;
        else
            pcnt <= pcnt + 1'b1;
    end
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            main_gate <= 1'b0;
        else
            main_gate <= gate_enable && mode != BLT_MODE_SKIP && pwm_on_req
                && !end_cyc && pcnt < max_on;
    end
endmodule
`default_nettype wire

// [blt_pkg.sv]
// Constants shared by the brownout and line level tracker.
// Assumes a single 200 MHz clock and a synchronous active-low reset.
// What this block does
// - At supply turn-on, stop both startup currents before judging line brown-in.
// - Ignore line comparators whenever the supply pin is being charged.
// - Start only after brown-in held for qualify delay and supply recharged.
// - Line below brown-out runs 300 us delay, then 50 ms stop timer.
// - Stop timer expiry declares brownout and stops gate drive at once.
// - Brown-in held for qualify delay clears the stop timer.
// - Power-up line classification is low line.
// - Line-dependent changes wait until soft start and its wait period end.
// - First line cycle raises recorded maximum at each higher trip level.
// - A two-step fall marks the maximum; held peak is maximum plus two.
// - Held peak updates only after the same new peak is seen twice.
// - Held peak moves at most one level per 32 ms.
// - Line comparator changes filtered over about 253 us.
// - Line removal stops switching and waits for AC return or supply reset.
// - Clamped flyback mode enforces 590 ns minimum off time each cycle.
// - Main-switch duty limited to about 78 percent.
// - In clamped mode at high frequency the minimum off time sets the duty limit.
// - Four modes: clamped variable frequency, transition, discontinuous, skip.
package blt_pkg;
    localparam int CLK_MHZ = 200;
    localparam int SHORT_DELAY_US = 300;
    localparam int LONG_TIMER_MS = 50;
    localparam int RATE_MS = 32;
    localparam int FILTER_US = 253;
    localparam int MIN_OFF_NS = 590;
    localparam int DUTY_PCT = 78;
    localparam int QUALIFY_US = 300;
    localparam int SHORT_CYC = SHORT_DELAY_US * CLK_MHZ;
    localparam int LONG_CYC = LONG_TIMER_MS * 1000 * CLK_MHZ;
    localparam int RATE_CYC = RATE_MS * 1000 * CLK_MHZ;
    localparam int FILTER_CYC = FILTER_US * CLK_MHZ;
    localparam int QUALIFY_CYC = QUALIFY_US * CLK_MHZ;
    localparam int MIN_OFF_CYC = (MIN_OFF_NS * CLK_MHZ + 999) / 1000;
    localparam int PEAK_ADD = 2;
    localparam int FALL_STEPS = 2;
    localparam int PCT_FULL = 100;
    typedef enum logic [3:0] {
        BLT_MODE_ACF = 4'h1,
        BLT_MODE_TRANS = 4'h2,
        BLT_MODE_DCM = 4'h4,
        BLT_MODE_SKIP = 4'h8
    } blt_mode_e;
    typedef enum logic [4:0] {
        BLT_ST_CHARGE = 5'h01,
        BLT_ST_QUALIFY = 5'h02,
        BLT_ST_RECHARGE = 5'h04,
        BLT_ST_RUN = 5'h08,
        BLT_ST_FAULT = 5'h10
    } blt_state_e;
endpackage

// [blt_filter.sv]
// Glitch filter for one comparator input.
// Assumes the input is already synchronised to mclk.
`timescale 1ns/10ps
`default_nettype none
module blt_filter
    import blt_pkg::*;
#(
    parameter int CYCLES = FILTER_CYC
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic raw,
    output logic clean
);
    logic [$clog2(CYCLES+1)-1:0] cnt;
    wire differs = raw != clean;
    wire done = cnt == ($clog2(CYCLES+1))'(CYCLES - 1);
    // A change must persist the full window before it is accepted
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            cnt <= '0;
            clean <= 1'b0;
        end
        else if (!differs)
            cnt <= '0;
        else if (done)
        begin
            cnt <= '0;
            clean <= raw;
        end
        else
            cnt <= cnt + 1'b1;
    end
endmodule
`default_nettype wire

// [blt_cmp_model.sv]
// Comparator model for the analog side of the tracker.
// Assumes the bench sets the line level and can drain the supply pin.
`timescale 1ns/10ps
`default_nettype none
module blt_cmp_model
(
    input wire logic mclk,
    input wire logic [3:0] line_lvl,
    input wire logic drain,
    input wire logic chg_low,
    input wire logic chg_high,
    output logic vcc_on,
    output logic vcc_reset,
    output logic vcc_inhibit,
    output logic bi,
    output logic bo,
    output logic [14:0] lvl
);
    int vcc = 0;
    // ****************
    // Supply pin
    // ****************
    // Supply only rises while a startup source charges it
    always @(posedge mclk)
    begin
        if (drain)
            vcc <= 0;
        else if (chg_high)
            vcc <= vcc + 3;
        else if (chg_low)
            vcc <= vcc + 1;
    end
    assign vcc_on = vcc >= 40;
    assign vcc_reset = vcc == 0;
    assign vcc_inhibit = vcc > 2;
    // Brown-in sits above brown-out for hysteresis
    assign bi = line_lvl >= 4'h6;
    assign bo = line_lvl >= 4'h4;
    always_comb
        for (int i = 0; i < 15; i++)
            lvl[i] = line_lvl > 4'(i);
endmodule
`default_nettype wire

// [blt_top_properties.sv]
// Checker on the tracker outputs, bound into blt_top.
// Assumes the bind hands on LW, PW and RATE_CYCLES.
`timescale 1ns/10ps
`default_nettype none
module blt_top_properties
    import blt_pkg::*;
#(
    parameter int LW = 4,
    parameter int PW = 16,
    parameter int RATE_CYCLES = RATE_CYC
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [PW-1:0] period_cycles,
    input wire logic startup_current_low,
    input wire logic startup_current_high,
    input wire logic start_sequence,
    input wire logic brownout,
    input wire logic line_fault,
    input wire logic gate_enable,
    input wire logic main_gate,
    input wire logic high_line,
    input wire logic [LW-1:0] held_peak_line_level,
    input wire logic [3:0] mode
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    int since;
    int on_run;
    int off_run;
    wire logic acf = mode == BLT_MODE_ACF;
    wire logic [LW-1:0] hp = held_peak_line_level;
    // since and off_run start saturated and on_run at zero so the first pulse after reset is legal
    always_ff @(posedge mclk)
    begin
        since <= !rst_n ? RATE_CYCLES : (hp != $past(hp) ? 0 : since + 1);
        on_run <= (rst_n && main_gate) ? on_run + 1 : 0;
        off_run <= !rst_n ? 1000 : (main_gate ? 0 : off_run + 1);
    end
    // ****************
    // Properties
    // ****************
    sequence s_pulse;
        start_sequence ##1 !start_sequence;
    endsequence
    a_start_currents_off: assert property (start_sequence |-> !startup_current_low && !startup_current_high)
        else $error("startup current on at start");
    a_start_one_pulse: assert property ($rose(start_sequence) |-> s_pulse)
        else $error("start pulse too long");
    a_brownout_no_gate: assert property (brownout |-> !gate_enable)
        else $error("gate enabled in brownout");
    a_brownout_stops_pulses: assert property ($rose(brownout) |=> !main_gate [*3])
        else $error("pulse after brownout");
    a_fault_no_gate: assert property (line_fault |-> !gate_enable)
        else $error("gate enabled in line fault");
    a_held_one_step: assert property ($changed(hp) |-> LW'(hp - $past(hp)) == 1 || LW'($past(hp) - hp) == 1)
        else $error("held peak jumped");
    a_held_rate_limit: assert property ($changed(hp) |-> since >= RATE_CYCLES - 1)
        else $error("held peak moved too soon");
    a_high_line_msb: assert property (high_line != hp[LW-1] |-> ##1 high_line == $past(hp[LW-1]))
        else $error("high line not held msb");
    a_mode_onehot: assert property ($onehot(mode))
        else $error("mode not one-hot");
    a_duty_limit: assert property (main_gate |-> on_run < period_cycles * DUTY_PCT / PCT_FULL)
        else $error("duty above limit");
    a_acf_off_time: assert property ($rose(main_gate) && acf |-> off_run >= MIN_OFF_CYC)
        else $error("off time too short");
    a_acf_duty_cap: assert property (main_gate && acf |-> on_run < period_cycles - MIN_OFF_CYC)
        else $error("on time leaves no off time");
endmodule
bind blt_top blt_top_properties #(.LW(LW), .PW(PW), .RATE_CYCLES(RATE_CYCLES)) blt_top_properties_i (
    .mclk(mclk), .rst_n(rst_n), .period_cycles(period_cycles),
    .startup_current_low(startup_current_low), .startup_current_high(startup_current_high),
    .start_sequence(start_sequence), .brownout(brownout), .line_fault(line_fault),
    .gate_enable(gate_enable), .main_gate(main_gate), .high_line(high_line),
    .held_peak_line_level(held_peak_line_level), .mode(mode));
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the brownout and line level tracker.
// Assumes shortened timers and the comparator model beside the design.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import blt_pkg::*;
    logic mclk = 0;
    logic rst_n = 0;
    logic ac_on = 1;
    logic drain = 0;
    logic ss_done = 0;
    logic allow = 0;
    logic pwm_on = 0;
    logic [3:0] line_lvl = 4'h0;
    logic [3:0] mode_req = 4'h4;
    logic [15:0] period = 16'h00C8;
    wire logic s_on, s_rst, s_inh, bi, bo, cur_lo, cur_hi, start_seq, bout, lfault, gate_en, gate;
    wire logic hi_line;
    wire logic [14:0] lvl;
    wire logic [3:0] cur, held, mode;
    int err_total = 0;
    int checks = 0;
    int n;
    int mx;
    int run;
    always #2.5 mclk = ~mclk;
    blt_top #(.LONG_CYCLES(40), .RATE_CYCLES(30), .QUALIFY_CYCLES(10),
        .SHORT_CYCLES(5), .FILTER_CYCLES(3)) blt_top_i (
        .mclk(mclk), .rst_n(rst_n), .supply_on_cmp(s_on), .supply_reset_cmp(s_rst),
        .supply_inhibit_cmp(s_inh), .brown_in_cmp(bi), .brown_out_cmp(bo),
        .line_present_cmp(ac_on), .level_cmp(lvl), .soft_start_done(ss_done),
        .line_changes_allowed(allow), .mode_req(mode_req), .pwm_on_req(pwm_on),
        .period_cycles(period), .startup_current_low(cur_lo), .startup_current_high(cur_hi),
        .start_sequence(start_seq), .brownout(bout), .line_fault(lfault),
        .gate_enable(gate_en), .main_gate(gate), .high_line(hi_line),
        .current_peak_line_level(cur), .held_peak_line_level(held), .mode(mode));
    blt_cmp_model blt_cmp_model_i (.mclk(mclk), .line_lvl(line_lvl), .drain(drain),
        .chg_low(cur_lo), .chg_high(cur_hi), .vcc_on(s_on), .vcc_reset(s_rst),
        .vcc_inhibit(s_inh), .bi(bi), .bo(bo), .lvl(lvl));
    // ****************
    // Helpers
    // ****************
    task tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task bound(input string what, input int lim);
        if (n >= lim)
        begin
            err_total++;
            $display("BAD %s expected event seen timeout", what);
            give_verdict();
        end
    endtask
    task give_verdict;
        $display("Mismatches %0d, checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ****************
    // Scenarios
    // ****************
    task do_reset;
        @(posedge mclk) rst_n <= 0;
        tick(3);
        chk("mode", 4'h4, mode);
        chk("held", 4'h0, held);
        chk("high_line", 1'b0, hi_line);
        chk("current_peak", 4'h0, cur);
        @(posedge mclk) rst_n <= 1;
        tick(2);
        chk("startup_low", 1'b1, cur_lo);
    endtask
    task t_start;
        @(posedge mclk) line_lvl <= 4'hA;
        for (n = 0; n < 500 && start_seq !== 1'b1; n++) tick(1);
        bound("start_sequence", 500);
        chk("startup_currents", 2'b00, {cur_lo, cur_hi});
        @(posedge mclk) ss_done <= 1;
    endtask
    task t_modes;
        for (int i = 3; i >= 0; i--)
        begin
            @(posedge mclk) mode_req <= 4'h1 << i;
            tick(4);
            chk("mode", 4'h1 << i, mode);
        end
        // Not one-hot, so the last good mode must stay
        @(posedge mclk) mode_req <= 4'h3;
        tick(4);
        chk("mode_refused", 4'h1, mode);
    endtask
    task t_duty(input logic [3:0] m, input int lim);
        @(posedge mclk) mode_req <= m;
        tick(200);
        @(posedge mclk) pwm_on <= 1;
        mx = 0;
        run = 0;
        for (n = 0; n < 800; n++)
        begin
            tick(1);
            run = (gate === 1'b1) ? run + 1 : 0;
            mx = (run > mx) ? run : mx;
        end
        @(posedge mclk) pwm_on <= 0;
        chk("on_time", 1'b1, mx <= lim && mx + 2 >= lim);
    endtask
    task wave(input logic [3:0] top);
        for (int v = 6; v <= top; v++)
        begin
            @(posedge mclk) line_lvl <= 4'(v);
            tick(8);
        end
        for (int v = 1; v <= 3; v++)
        begin
            @(posedge mclk) line_lvl <= top - 4'(v);
            tick(8);
        end
    endtask
    task t_peak;
        repeat (3) wave(4'h9);
        chk("held_locked", 4'h0, held);
        chk("current_locked", 4'h0, cur);
        @(posedge mclk) allow <= 1;
        for (n = 0; n < 20 && held !== 4'hB; n++) wave(4'h9);
        bound("held_peak", 20);
        // High line follows the held peak one edge later
        tick(2);
        chk("high_line", 1'b1, hi_line);
        @(posedge mclk) line_lvl <= 4'hF;
        @(posedge mclk) line_lvl <= 4'h6;
        // Watch every edge, an unfiltered glitch would pass in a few cycles
        mx = 0;
        for (n = 0; n < 8; n++)
        begin
            tick(1);
            mx = (cur === 4'hF) ? 1 : mx;
        end
        chk("glitch_level", 1'b0, mx != 0);
    endtask
    task t_brown;
        @(posedge mclk) line_lvl <= 4'h2;
        tick(15);
        @(posedge mclk) line_lvl <= 4'hA;
        tick(80);
        chk("brownout_cleared", 1'b0, bout);
        @(posedge mclk) line_lvl <= 4'h2;
        // Without the short delay the stop timer would already have expired
        tick(48);
        chk("brownout_early", 1'b0, bout);
        for (n = 0; n < 60 && bout !== 1'b1; n++) tick(1);
        bound("brownout", 60);
        chk("gate_enable", 1'b0, gate_en);
    endtask
    task t_remove;
        do_reset();
        t_start();
        // First leave the wait state by AC return, then by supply reset
        for (int k = 0; k < 2; k++)
        begin
            @(posedge mclk) ac_on <= 0;
            for (n = 0; n < 60 && lfault !== 1'b1; n++) tick(1);
            bound("line_fault", 60);
            chk("gate_enable", 1'b0, gate_en);
            chk("wait_state", 1'b0, cur_lo);
            if (k == 0)
                @(posedge mclk) ac_on <= 1;
            else
                @(posedge mclk) drain <= 1;
            for (n = 0; n < 60 && cur_lo !== 1'b1; n++) tick(1);
            bound("recharge", 60);
            // Fault flag clears one edge after the charge state is entered
            tick(2);
            chk("line_fault", 1'b0, lfault);
        end
    endtask
    initial
    begin
        do_reset();
        t_start();
        t_modes();
        t_duty(4'h1, 200 - MIN_OFF_CYC);
        t_duty(4'h4, 200 * DUTY_PCT / PCT_FULL);
        t_duty(4'h8, 0);
        t_peak();
        t_brown();
        t_remove();
        give_verdict();
    end
endmodule
`default_nettype wire
